// ===== logic/fdcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module fdcs_top
  import fdcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic irq_out,
  input wire logic second_drive_absent_n_in,
  input wire logic step_n_in,
  input wire logic track_zero_n_in,
  input wire logic head_select_n_in,
  input wire logic index_n_in,
  input wire logic write_prot_n_in,
  input wire logic step_dir_in,
  input wire logic dma_request_in,
  input wire logic drive_fault_in,
  input wire logic drive_ready_in,
  input wire logic two_side_in,
  output logic [1:0] drive_sel_out,
  output logic lock_out,
  output logic overwrite_flag_out,
  output logic [3:0] perp_drive_out,
  output logic gap_sel_out,
  output logic write_gate_select_out
);

  // All bus-side state in one word
  typedef struct packed {
    logic hready;           // Bus ready, low during the wait state
    logic hresp;            // Always OKAY
    logic [31:0] hrdata;    // Registered read data
    logic pend;             // Data phase in progress
    logic pwrite;           // Captured direction
    logic pmapped;          // Captured address hits a register
    logic [3:0] pidx;       // Captured register index
    logic mode;             // 0 first layout, 1 second layout
    logic [7:0] dor;        // Drive output control
    logic [1:0] tape;       // Tape drive assignment
    logic [7:0] rate;       // Data rate select
    logic [1:0] ccr;        // Configuration control
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;              // Floppy interrupt level
    logic step_q;           // Latched copy of the step output
    logic wr_valid;         // Command byte strobe to the engine
    logic [7:0] wr_data;
    logic rd_take;          // Result byte consumed
  } fdcs_regs_t;

  // Step latch resets high, the idle level of its active-low pin
  localparam fdcs_regs_t RESET_ST = '{hready: HREADY_RST, step_q: 1'b1, default: '0};

  fdcs_regs_t st;
  fdcs_regs_t next_st;
  logic [IRQ_W-1:0] events;  // Engine events this cycle
  logic [7:0] pins_a;        // Raw pin levels feeding status A

  fdcs_cmd_if cmd ();

  // Command engine holds the command phase and its settings
  fdcs_cmd_engine u_engine (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .cmd(cmd)
  );

  // Drive condition bits for the third status byte
  assign cmd.st3_flags = {drive_fault_in, ~write_prot_n_in, drive_ready_in, ~track_zero_n_in, two_side_in};
  assign cmd.wr_valid = st.wr_valid;
  assign cmd.wr_data = st.wr_data;
  assign cmd.rd_take = st.rd_take;

  // Engine pulses feed the sticky status bits
  assign events[IRQ_DONE_BIT] = cmd.done;
  assign events[IRQ_INVALID_BIT] = cmd.invalid;

  // Pins in status A order, before any inversion
  assign pins_a = {1'b0, second_drive_absent_n_in, step_n_in, track_zero_n_in,
                   head_select_n_in, index_n_in, write_prot_n_in, step_dir_in};

  // Register index decode; misaligned or out-of-range addresses miss
  function automatic logic [4:0] decode_reg(input logic [31:0] addr);
    logic hit;
    logic [3:0] idx;
    idx = addr[5:2];
    hit = (addr[31:6] == 26'h0) && (addr[1:0] == 2'b00);
    case (idx)
      IDX_SA, IDX_SB, IDX_DO, IDX_TD, IDX_MS, IDX_FIFO, IDX_DI, IDX_MODE, IDX_ISTAT, IDX_IMASK: begin
        hit = hit;
      end
      default: begin
        hit = 1'b0; // Index 6 and indices 11 to 15 answer zero
      end
    endcase
    return {hit, idx};
  endfunction

  // Status A image from current pins; pure, so reading it changes nothing
  function automatic logic [7:0] status_a(input logic mode, input logic irq, input logic step_q,
                                          input logic dma_request, input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    v[SA_IRQ_BIT] = irq;
    if (!mode) begin
      v[SA_B6_BIT] = p[SA_B6_BIT];
      v[SA_STEP_BIT] = ~p[SA_STEP_BIT];
      v[SA_TRACK0_BIT] = p[SA_TRACK0_BIT];
      v[SA_HEAD_BIT] = ~p[SA_HEAD_BIT];
      v[SA_INDEX_BIT] = p[SA_INDEX_BIT];
      v[SA_WPROT_BIT] = p[SA_WPROT_BIT];
      v[SA_DIR_BIT] = p[SA_DIR_BIT];
    end else begin
      v[SA_B6_BIT] = dma_request;
      v[SA_STEP_BIT] = ~step_q;
      v[SA_TRACK0_BIT] = ~p[SA_TRACK0_BIT];
      v[SA_HEAD_BIT] = p[SA_HEAD_BIT];
      v[SA_INDEX_BIT] = ~p[SA_INDEX_BIT];
      v[SA_WPROT_BIT] = ~p[SA_WPROT_BIT];
      v[SA_DIR_BIT] = ~p[SA_DIR_BIT];
    end
    return v;
  endfunction

  // Bus slave, register file and interrupt logic
  always_comb begin
    next_st = st;
    next_st.wr_valid = 1'b0;
    next_st.rd_take = 1'b0;
    next_st.hresp = 1'b0;
    next_st.step_q = step_n_in;
    if (st.pend) begin
      // Data phase: one wait state keeps read data straight from a flop
      next_st.pend = 1'b0;
      next_st.hready = 1'b1;
      next_st.hrdata = 32'h0000_0000;
      // Writes land on the edge that ends the wait state
      if (st.pmapped && st.pwrite) begin
        case (st.pidx)
          IDX_DO: begin
            next_st.dor = hwdata_in[7:0];
          end
          IDX_TD: begin
            next_st.tape = hwdata_in[1:0];
          end
          IDX_MS: begin
            next_st.rate = hwdata_in[7:0];
          end
          IDX_FIFO: begin
            // Byte goes to the engine next cycle
            next_st.wr_valid = 1'b1;
            next_st.wr_data = hwdata_in[7:0];
          end
          IDX_DI: begin
            next_st.ccr = hwdata_in[1:0];
          end
          IDX_MODE: begin
            next_st.mode = hwdata_in[0];
          end
          IDX_ISTAT: begin
            next_st.irq_stat = st.irq_stat & ~hwdata_in[IRQ_W-1:0];
          end
          IDX_IMASK: begin
            next_st.irq_mask = hwdata_in[IRQ_W-1:0];
          end
          default: begin
            next_st.dor = st.dor; // Read-only words ignore writes
          end
        endcase
      end else if (st.pmapped) begin
        // Read data registered here so hrdata_out is a flop
        case (st.pidx)
          IDX_SA: begin
            next_st.hrdata = {24'h0, status_a(st.mode, st.irq, st.step_q, dma_request_in, pins_a)};
          end
          IDX_TD: begin
            next_st.hrdata = {30'h0, st.tape};
          end
          IDX_MS: begin
            next_st.hrdata[MS_RESULT_BIT] = cmd.res_valid;
            next_st.hrdata[MS_BUSY_BIT] = cmd.busy;
          end
          IDX_FIFO: begin
            // Reading the result byte ends the result phase
            next_st.hrdata = {24'h0, cmd.res_data};
            next_st.rd_take = cmd.res_valid;
          end
          IDX_MODE: begin
            next_st.hrdata = {31'h0, st.mode};
          end
          IDX_ISTAT: begin
            next_st.hrdata = {30'h0, st.irq_stat};
          end
          IDX_IMASK: begin
            next_st.hrdata = {30'h0, st.irq_mask};
          end
          default: begin
            next_st.hrdata = 32'h0000_0000; // Status B, input status, write-only words
          end
        endcase
      end
    end else if (hsel_in && hready_in && htrans_in[1]) begin
      // Address phase taken; size is ignored, only whole words are used
      next_st.pend = 1'b1;
      next_st.hready = 1'b0;
      next_st.pwrite = hwrite_in;
      {next_st.pmapped, next_st.pidx} = decode_reg(haddr_in);
    end
    // Events after the clear, so a set in the clearing cycle survives
    next_st.irq_stat = next_st.irq_stat | events;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  // Single state register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops, never through logic
  assign hrdata_out = st.hrdata;
  assign hreadyout_out = st.hready;
  assign hresp_out = st.hresp;
  assign irq_out = st.irq;
  assign drive_sel_out = st.dor[1:0];
  assign lock_out = cmd.lock;
  assign overwrite_flag_out = cmd.overwrite_flag;
  assign perp_drive_out = cmd.perp_drive;
  assign gap_sel_out = cmd.gap_sel;
  assign write_gate_select_out = cmd.write_gate_select;

  // Bus checks, all on the system clock and off during reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_addr_taken;
    hsel_in && hready_in && htrans_in[1] && hreadyout_out;
  endsequence

  sequence s_read_sa;
    st.pend && !st.pwrite && st.pmapped && (st.pidx == IDX_SA);
  endsequence

  a_bus_wait_state: assert property (s_addr_taken |=> !hreadyout_out ##1 hreadyout_out && !hresp_out)
    else $error("wait state not one cycle");

  a_sa_irq_bit: assert property (s_read_sa |=> hrdata_out[7] == $past(irq_out))
    else $error("status A bit7 not interrupt level");

  a_sa_first_mode: assert property (s_read_sa and (!st.mode) |=> hrdata_out[6:0] ==
    $past({second_drive_absent_n_in, ~step_n_in, track_zero_n_in, ~head_select_n_in,
           index_n_in, write_prot_n_in, step_dir_in}))
    else $error("status A first layout wrong");

  a_sa_second_mode: assert property (s_read_sa and st.mode |=> hrdata_out[6:0] ==
    $past({dma_request_in, ~st.step_q, ~track_zero_n_in, head_select_n_in,
           ~index_n_in, ~write_prot_n_in, ~step_dir_in}))
    else $error("status A second layout wrong");

  a_invalid_result: assert property (cmd.invalid |-> cmd.res_valid && cmd.res_data == ST0_INVALID)
    else $error("invalid command result not 80H");

  a_unmapped_zero: assert property (st.pend && !st.pwrite && !st.pmapped |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");

  a_set_beats_clear: assert property (st.pend && st.pwrite && st.pmapped && st.pidx == IDX_ISTAT &&
    hwdata_in[IRQ_DONE_BIT] && cmd.done |=> st.irq_stat[IRQ_DONE_BIT])
    else $error("event lost under clear");

  a_irq_raise: assert property (cmd.done && st.irq_mask[IRQ_DONE_BIT] |=> irq_out ##1 irq_out [*1])
    else $error("interrupt not raised");

  // Data phase of a write that lands in a mapped word
  sequence s_write_hit;
    st.pend && st.pwrite && st.pmapped;
  endsequence

  // The slave has no error case, so every response is OKAY
  a_resp_okay: assert property (!hresp_out)
    else $error("bus response not okay");

  // Drive select follows the output control word one edge later
  a_dor_write: assert property (s_write_hit and (st.pidx == IDX_DO) |=>
    drive_sel_out == $past(hwdata_in[1:0]))
    else $error("drive select not written");

  // Layout select takes the new mode at the write, one edge later
  a_mode_write: assert property (s_write_hit and (st.pidx == IDX_MODE) |=>
    st.mode == $past(hwdata_in[0]))
    else $error("mode select not written");

  // Reading status A must not disturb mode, lock or the result phase
  a_sa_no_effect: assert property (s_read_sa |=> $stable(st.mode) && $stable(cmd.lock) && !st.rd_take)
    else $error("status A read had a side effect");

  // Latched step copy trails the pin by exactly one clock
  a_step_latch: assert property (1'b1 |=> st.step_q == $past(step_n_in))
    else $error("step latch not one clock behind");

  // Write one to clear, when no event lands in the same cycle
  a_istat_clear: assert property (s_write_hit and (st.pidx == IDX_ISTAT) and (events == '0) |=>
    st.irq_stat == ($past(st.irq_stat) & ~$past(hwdata_in[IRQ_W-1:0])))
    else $error("status bits not cleared");

  // A write to the data port hands its byte to the engine one cycle on
  a_cmd_byte: assert property (s_write_hit and (st.pidx == IDX_FIFO) |=>
    st.wr_valid && (st.wr_data == $past(hwdata_in[7:0])))
    else $error("command byte not passed on");

  // Reading the data port returns the waiting result byte
  a_result_read: assert property (st.pend && !st.pwrite && st.pmapped && (st.pidx == IDX_FIFO) |=>
    hrdata_out == {24'h0, $past(cmd.res_data)})
    else $error("result byte not returned");

endmodule
`default_nettype wire

// ===== shared/fdcs_pkg.sv
package fdcs_pkg;

  // Register indices: each index is one aligned 32-bit word, byte address = index * 4
  localparam int REG_IDX_W = 4;
  localparam logic [3:0] IDX_SA = 4'h0;       // disk_status_a, read
  localparam logic [3:0] IDX_SB = 4'h1;       // pin_status_b, read
  localparam logic [3:0] IDX_DO = 4'h2;       // drive_output_ctrl, write
  localparam logic [3:0] IDX_TD = 4'h3;       // tape_drive_assign, read/write
  localparam logic [3:0] IDX_MS = 4'h4;       // main status read, data rate write
  localparam logic [3:0] IDX_FIFO = 4'h5;     // data_fifo_port
  localparam logic [3:0] IDX_DI = 4'h7;       // input status read, config control write
  localparam logic [3:0] IDX_MODE = 4'h8;     // compatibility mode select
  localparam logic [3:0] IDX_ISTAT = 4'h9;    // interrupt status, write one to clear
  localparam logic [3:0] IDX_IMASK = 4'hA;    // interrupt mask

  // Byte addresses seen on the bus
  localparam logic [31:0] ADDR_SA = 32'h0000_0000;
  localparam logic [31:0] ADDR_SB = 32'h0000_0004;
  localparam logic [31:0] ADDR_DO = 32'h0000_0008;
  localparam logic [31:0] ADDR_TD = 32'h0000_000C;
  localparam logic [31:0] ADDR_MS = 32'h0000_0010;
  localparam logic [31:0] ADDR_FIFO = 32'h0000_0014;
  localparam logic [31:0] ADDR_DI = 32'h0000_001C;
  localparam logic [31:0] ADDR_MODE = 32'h0000_0020;
  localparam logic [31:0] ADDR_ISTAT = 32'h0000_0024;
  localparam logic [31:0] ADDR_IMASK = 32'h0000_0028;

  // Status register A bit positions
  localparam int SA_IRQ_BIT = 7;
  localparam int SA_B6_BIT = 6;
  localparam int SA_STEP_BIT = 5;
  localparam int SA_TRACK0_BIT = 4;
  localparam int SA_HEAD_BIT = 3;
  localparam int SA_INDEX_BIT = 2;
  localparam int SA_WPROT_BIT = 1;
  localparam int SA_DIR_BIT = 0;

  // Main status bit positions
  localparam int MS_RESULT_BIT = 6;
  localparam int MS_BUSY_BIT = 4;

  // Command codes and fields
  localparam logic [7:0] CMD_PERP = 8'h12;
  localparam logic [6:0] CMD_LOCK = 7'h14;
  localparam logic [7:0] CMD_SDS = 8'h04;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam int LOCK_CMD_BIT = 7;
  localparam int LOCK_RES_BIT = 4;
  localparam int PERP_OW_BIT = 7;
  localparam int PERP_DRV_LSB = 2;
  localparam int PERP_GAP_BIT = 1;
  localparam int PERP_WG_BIT = 0;
  localparam int SDS_HDS_BIT = 2;

  // Interrupt status / mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_INVALID_BIT = 1;

  // Reset values
  localparam logic HREADY_RST = 1'b1;
  localparam logic [7:0] RESULT_RST = 8'h00;

  // Command engine states
  typedef enum logic [1:0] {
    CS_IDLE,
    CS_WAIT_PERP,
    CS_WAIT_SDS,
    CS_RESULT
  } fdcs_cmd_state_t;

endpackage

// ===== shared/fdcs_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fdcs_cmd_if;
  logic wr_valid;            // One command byte this cycle
  logic [7:0] wr_data;       // Command byte
  logic rd_take;             // Host has read the result byte
  logic [4:0] st3_flags;     // fault, write protect, ready, track zero, two side
  logic res_valid;           // Result byte waiting
  logic [7:0] res_data;      // Result byte
  logic busy;                // Waiting for a second command byte
  logic done;                // Pulse: result phase entered
  logic invalid;             // Pulse: unrecognised command
  logic lock;
  logic overwrite_flag;
  logic [3:0] perp_drive;
  logic gap_sel;
  logic write_gate_select;

  modport host (output wr_valid, wr_data, rd_take, st3_flags,
                input res_valid, res_data, busy, done, invalid, lock, overwrite_flag,
                perp_drive, gap_sel, write_gate_select);
  modport engine (input wr_valid, wr_data, rd_take, st3_flags,
                  output res_valid, res_data, busy, done, invalid, lock, overwrite_flag,
                  perp_drive, gap_sel, write_gate_select);
endinterface
`default_nettype wire

// ===== logic/fdcs_cmd_engine.sv
`timescale 1ns/1ps
`default_nettype none
module fdcs_cmd_engine
  import fdcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  fdcs_cmd_if.engine cmd
);

  // All engine state in one word
  typedef struct packed {
    fdcs_cmd_state_t state;
    logic [7:0] res;
    logic lock;
    logic ow;
    logic [3:0] perp;
    logic gap;
    logic wg;
    logic done;
    logic invalid;
  } fdcs_eng_t;

  fdcs_eng_t st;
  fdcs_eng_t next_st;

  // Command decode; a new command byte abandons any unread result
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.invalid = 1'b0;
    unique case (st.state)
      CS_IDLE, CS_RESULT: begin
        if (cmd.rd_take) begin
          next_st.state = CS_IDLE;
        end
        if (cmd.wr_valid) begin
          if (cmd.wr_data == CMD_PERP) begin
            next_st.state = CS_WAIT_PERP;
          end else if (cmd.wr_data[6:0] == CMD_LOCK) begin
            // Lock value echoed alone in the result byte
            next_st.lock = cmd.wr_data[LOCK_CMD_BIT];
            next_st.res = RESULT_RST;
            next_st.res[LOCK_RES_BIT] = cmd.wr_data[LOCK_CMD_BIT];
            next_st.state = CS_RESULT;
            next_st.done = 1'b1;
          end else if (cmd.wr_data == CMD_SDS) begin
            next_st.state = CS_WAIT_SDS;
          end else begin
            // Unknown code: no operation, one status byte
            next_st.res = ST0_INVALID;
            next_st.state = CS_RESULT;
            next_st.done = 1'b1;
            next_st.invalid = 1'b1;
          end
        end
      end
      CS_WAIT_PERP: begin
        if (cmd.wr_valid) begin
          next_st.ow = cmd.wr_data[PERP_OW_BIT];
          next_st.perp = cmd.wr_data[PERP_DRV_LSB +: 4];
          next_st.gap = cmd.wr_data[PERP_GAP_BIT];
          next_st.wg = cmd.wr_data[PERP_WG_BIT];
          next_st.state = CS_IDLE;
        end
      end
      CS_WAIT_SDS: begin
        if (cmd.wr_valid) begin
          // Third status byte for the drive named in the second byte
          next_st.res = {cmd.st3_flags, cmd.wr_data[SDS_HDS_BIT:0]};
          next_st.state = CS_RESULT;
          next_st.done = 1'b1;
        end
      end
    endcase
  end

  // State register; lock and perpendicular settings clear at reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cmd.res_valid = (st.state == CS_RESULT);
  assign cmd.res_data = st.res;
  assign cmd.busy = (st.state == CS_WAIT_PERP) || (st.state == CS_WAIT_SDS);
  assign cmd.done = st.done;
  assign cmd.invalid = st.invalid;
  assign cmd.lock = st.lock;
  assign cmd.overwrite_flag = st.ow;
  assign cmd.perp_drive = st.perp;
  assign cmd.gap_sel = st.gap;
  assign cmd.write_gate_select = st.wg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_lock_cmd;
    (st.state != CS_WAIT_PERP) && (st.state != CS_WAIT_SDS) && cmd.wr_valid &&
      (cmd.wr_data[6:0] == CMD_LOCK);
  endsequence

  a_lock_result: assert property (s_lock_cmd |=> cmd.res_valid &&
    (cmd.res_data == {3'b000, $past(cmd.wr_data[7]), 4'b0000}) && cmd.lock == $past(cmd.wr_data[7]))
    else $error("lock result byte wrong");

  sequence s_sds_cmd;
    (st.state == CS_IDLE) && cmd.wr_valid && (cmd.wr_data == CMD_SDS);
  endsequence

  // Second byte, however long the host took to send it
  sequence s_sds_drive;
    (st.state == CS_WAIT_SDS) && cmd.wr_valid;
  endsequence

  a_sds_wait: assert property (s_sds_cmd |=> cmd.busy && !cmd.res_valid)
    else $error("drive status not waiting for byte two");

  a_sds_result: assert property (s_sds_drive |=>
    cmd.res_valid && cmd.res_data == {$past(cmd.st3_flags), $past(cmd.wr_data[2:0])})
    else $error("drive status result wrong");

  a_perp_fields: assert property ((st.state == CS_WAIT_PERP) && cmd.wr_valid |=>
    !cmd.res_valid && cmd.perp_drive == $past(cmd.wr_data[5:2]) && cmd.gap_sel == $past(cmd.wr_data[1]))
    else $error("perpendicular fields not stored");

endmodule
`default_nettype wire

// ===== verif/fdcs_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// Drive cable levels, set by the bench and launched on the clock
module fdcs_drive_model (
  input wire logic clk_in,
  input wire logic [10:0] lv_in,
  output logic [10:0] pins_out
);
  // Registered so the pins move just after an edge, like a real cable
  always_ff @(posedge clk_in) begin
    pins_out <= lv_in;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fdcs_pkg::*;
  logic clk = 1'b0; // 125 MHz system clock
  logic rstn = 1'b0; // Active low reset
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [10:0] lv = 11'h0; // Commanded drive pin levels
  logic [31:0] rd; // Last read data
  logic [10:0] pat [4] = '{11'h000, 11'h7FF, 11'h555, 11'h2AA}; // Each pin seen at both levels
  wire logic [31:0] hrdata;
  wire logic hready, hresp, irq, lock, ow, gap, wg;
  wire logic [1:0] dsel;
  wire logic [3:0] perp;
  wire logic [10:0] pin;
  int fails = 0;
  int num_checks = 0;

  fdcs_drive_model i_fdcs_drive_model (.clk_in(clk), .lv_in(lv), .pins_out(pin));
  fdcs_top i_fdcs_top (.clk_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .irq_out(irq), .second_drive_absent_n_in(pin[0]), .step_n_in(pin[1]),
    .track_zero_n_in(pin[2]), .head_select_n_in(pin[3]), .index_n_in(pin[4]),
    .write_prot_n_in(pin[5]), .step_dir_in(pin[6]), .dma_request_in(pin[7]),
    .drive_fault_in(pin[8]), .drive_ready_in(pin[9]), .two_side_in(pin[10]),
    .drive_sel_out(dsel), .lock_out(lock), .overwrite_flag_out(ow), .perp_drive_out(perp),
    .gap_sel_out(gap), .write_gate_select_out(wg));

  // Free running clock
  initial begin
    forever #4 clk = ~clk;
  end

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end

  // Count one comparison, report a mismatch at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // One single AHB transfer; only the watchdog ends a wait on a stuck slave
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Read and compare
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask

  // Poll main status until a result byte waits, for at most 8 reads; no fixed latency assumed
  task automatic poll;
    for (int i = 0; i < 8; i++) begin
      xfer(ADDR_MS, 1'b0, 32'h0);
      if (rd[MS_RESULT_BIT] === 1'b1) break;
    end
  endtask

  // Expected status A for a layout, pin set and interrupt level
  function automatic logic [31:0] sa(input logic m, input logic [10:0] p, input logic q);
    if (m) return {24'h0, q, p[7], ~p[1], ~p[2], p[3], ~p[4], ~p[5], ~p[6]};
    return {24'h0, q, p[0], ~p[1], p[2], ~p[3], p[4], p[5], p[6]};
  endfunction

  // Main test sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({lock, ow, perp, gap, wg, dsel}, 32'h0);
    rdc(ADDR_MODE, 32'h0);
    rdc(ADDR_ISTAT, 32'h0);
    // Stored word, write-only word, hole, read-only word
    xfer(ADDR_TD, 1'b1, 32'hFF);
    rdc(ADDR_TD, 32'h3);
    xfer(ADDR_DO, 1'b1, 32'h2);
    rdc(ADDR_DO, 32'h0);
    chk(dsel, 32'h2);
    rdc(32'h18, 32'h0);
    rdc(ADDR_SB, 32'h0);
    xfer(ADDR_MS, 1'b1, 32'hFF);
    rdc(ADDR_MS, 32'h0);
    xfer(ADDR_DI, 1'b1, 32'h3);
    rdc(ADDR_DI, 32'h0);
    xfer(ADDR_SA, 1'b1, 32'hFF);
    rdc(ADDR_SA, sa(1'b0, lv, 1'b0));
    chk(hresp, 32'h0);
    // Lock set then cleared, one result byte each
    for (int i = 1; i >= 0; i--) begin
      xfer(ADDR_FIFO, 1'b1, {24'h0, i[0], CMD_LOCK});
      poll;
      chk(rd, 32'h40);
      rdc(ADDR_FIFO, {27'h0, i[0], 4'h0});
      chk(lock, {31'h0, i[0]});
    end
    rdc(ADDR_MS, 32'h0);
    // Perpendicular setup: busy between bytes, no result phase
    xfer(ADDR_FIFO, 1'b1, {24'h0, CMD_PERP});
    rdc(ADDR_MS, 32'h10);
    xfer(ADDR_FIFO, 1'b1, 32'hAD);
    rdc(ADDR_MS, 32'h0);
    chk({ow, perp, gap, wg}, 32'h6D);
    // Sense drive status with two pin sets and selections
    for (int i = 0; i < 2; i++) begin
      lv <= i ? 11'h6AA : 11'h155;
      xfer(ADDR_FIFO, 1'b1, {24'h0, CMD_SDS});
      xfer(ADDR_FIFO, 1'b1, i ? 32'h6 : 32'h1);
      poll;
      rdc(ADDR_FIFO, {24'h0, lv[8], ~lv[5], lv[9], ~lv[2], lv[10], (i ? 3'h6 : 3'h1)});
      rdc(ADDR_MS, 32'h0);
    end
    // Unknown codes; interrupt masked, unmasked, then cleared
    for (int i = 0; i < 2; i++) begin
      xfer(ADDR_FIFO, 1'b1, i ? 32'hFF : 32'h0);
      poll;
      rdc(ADDR_FIFO, {24'h0, ST0_INVALID});
      rdc(ADDR_ISTAT, 32'h3);
      chk(irq, 32'h0);
      xfer(ADDR_IMASK, 1'b1, i ? 32'h1 : 32'h2);
      xfer(ADDR_MODE, 1'b1, i);
      chk(irq, 32'h1);
      rdc(ADDR_SA, sa(i[0], lv, 1'b1));
      xfer(ADDR_ISTAT, 1'b1, 32'h3);
      rdc(ADDR_ISTAT, 32'h0);
      chk(irq, 32'h0);
      rdc(ADDR_SA, sa(i[0], lv, 1'b0));
      xfer(ADDR_IMASK, 1'b1, 32'h0);
    end
    // Both layouts per pin set; the layout follows the mode at once
    for (int j = 0; j < 4; j++) begin
      lv <= pat[j];
      for (int m = 0; m < 2; m++) begin
        xfer(ADDR_MODE, 1'b1, {31'h0, m[0]});
        rdc(ADDR_SA, sa(m[0], pat[j], 1'b0));
      end
    end
    // Lock set, then a reset in mid-run clears every command setting
    xfer(ADDR_FIFO, 1'b1, {24'h0, 1'b1, CMD_LOCK});
    poll;
    chk(lock, 32'h1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({lock, ow, perp, gap, wg, dsel}, 32'h0);
    chk({hready, irq}, 32'h2);
    rdc(ADDR_MS, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
